/* dsq_map.svh */
// Register offsets, field positions and codes of the channel sequencer
`ifndef DSQ_MAP_SVH
`define DSQ_MAP_SVH
`define DSQ_CH_SHIFT    6
`define DSQ_NUM_CH      3'h6
`define DSQ_R_SRC       6'h00
`define DSQ_R_DST       6'h04
`define DSQ_R_ELEM      6'h08
`define DSQ_R_SYNCFRM   6'h0c
`define DSQ_R_MODE      6'h10
`define DSQ_R_RL_SRC    6'h14
`define DSQ_R_RL_DST    6'h18
`define DSQ_R_RL_ELEM   6'h1c
`define DSQ_R_RL_FRM    6'h20
`define DSQ_G_CTRL      12'h180
`define DSQ_G_ESTEP0    12'h184
`define DSQ_G_ESTEP1    12'h188
`define DSQ_G_FSTEP0    12'h18c
`define DSQ_G_FSTEP1    12'h190
`define DSQ_CTRL_RESET  16'h0000
`define DSQ_B_RLSEL     14
`define DSQ_F_PRIO      13:8
`define DSQ_F_IRQSEL    7:6
`define DSQ_F_EN        5:0
`define DSQ_B_AUTO      15
`define DSQ_B_INTGEN    14
`define DSQ_B_INTMODE   13
`define DSQ_B_ABU       12
`define DSQ_F_SIDX      10:8
`define DSQ_F_DIDX      2:0
`define DSQ_F_SYNC      15:12
`define DSQ_B_DBL       11
`define DSQ_F_FRM       7:0
`define DSQ_IDX_INC     3'h1
`define DSQ_IDX_DEC     3'h2
`define DSQ_IDX_SEL0    3'h3
`define DSQ_IDX_SEL1    3'h4
`define DSQ_SYNC_NONE   4'h0
`define DSQ_SYNC_RSVD   4'hf
`define DSQ_IRQ_PORTS   2'h0
`define DSQ_IRQ_HALF    2'h1
`define DSQ_IRQ_ALL     2'h2
`endif

/* dsq_pkg.sv */
// Types shared by the channel sequencer
`default_nettype none
package dsq_pkg;
  typedef enum logic [1:0] {
    DSQ_IDLE  = 2'b00,
    DSQ_READ  = 2'b01,
    DSQ_WRITE = 2'b11
  } dsq_state_t;
endpackage
`default_nettype wire

/* dsq_channel_sequencer.sv */
// Six-channel transfer sequencer with APB register access
// What this block does
// - With auto reload on, block end reloads working registers from reload set
// - Reload select bit: clear uses set zero, set uses own set
// - Frame counter decrements on the final read of each frame
// - Frame count zero means exactly one frame; maximum value is ff
// - After last frame with auto reload, frame counter reloads from set
// - Element counter decrements after each element read; ffff is longest
// - After last frame with auto reload, element counter reloads from set
// - Doubleword: two 16-bit transfers, addresses step each, one element
// - Index selects pick element step and matching frame step register
// - Non-final transfers of a frame add the selected element step
// - Final transfer of a frame adds the selected frame step instead
// - No interrupt unless the interrupt generation bit is set
// - Auto-buffer: full only in mode 0, half and full in mode 1
// - Multiframe: mode 0 at block end, mode 1 at each frame end
// - Four-bit sync field selects trigger event; 0 none, f reserved
// - Six separate done interrupts; channels 0-3 share port lines
// - Line select: 0 ports, 1 channels 2-3 upper, 2 channels 0-3 on all four lines
// - High priority first; equal priority served round robin
`default_nettype none
`include "dsq_map.svh"
module dsq_channel_sequencer
  import dsq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Memory side
  output logic             memReq,
  output logic             memWe,
  output var  logic [15:0] memAddr,
  output var  logic [15:0] memWdata,
  input  wire logic [15:0] memRdata,
  input  wire logic        memAck,
  // Sync events from pins: ports 0,2,1 rx/tx, bit-select rx/tx, timer, ext 3
  input  wire logic [13:0] syncIn,
  // Serial port interrupts sharing lines
  input  wire logic        port2RxIrq,
  input  wire logic        port2TxIrq,
  input  wire logic        port1RxIrq,
  input  wire logic        port1TxIrq,
  // Interrupts
  output var  logic [5:0]  chanDoneIrq,
  output logic             irqLine6,
  output logic             irqLine7,
  output logic             irqLine10,
  output logic             irqLine11
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] stepOf(input logic [2:0] sel, input logic last,
                                         input logic [15:0] e0, input logic [15:0] e1,
                                         input logic [15:0] f0, input logic [15:0] f1);
    if (sel == `DSQ_IDX_INC) return 16'h0001;
    else if (sel == `DSQ_IDX_DEC) return 16'hffff;
    else if (sel == `DSQ_IDX_SEL0) return last ? f0 : e0;
    else if (sel == `DSQ_IDX_SEL1) return last ? f1 : e1;
    else return 16'h0000;
  endfunction

  function automatic logic [3:0] pick(input logic [5:0] req, input logic [2:0] last);
    logic [3:0] res;
    logic [2:0] j;
    res = 4'h0;
    j = last;
    for (int i = 0; i < 6; i++) begin
      j = (j == 3'h5) ? 3'h0 : j + 3'h1;
      if (!res[3] && req[j]) res = {1'b1, j};
    end
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] ctrl_r;
  logic [15:0] eStep0_r, eStep1_r, fStep0_r, fStep1_r;
  logic [15:0] srcA_r [6];
  logic [15:0] dstA_r [6];
  logic [15:0] elemCnt_r [6];
  logic [15:0] elemInit_r [6];
  logic [15:0] abuPos_r [6];
  logic [15:0] sfc_r [6];
  logic [15:0] mode_r [6];
  logic [15:0] rlSrc_r [6];
  logic [15:0] rlDst_r [6];
  logic [15:0] rlElem_r [6];
  logic [15:0] rlFrm_r [6];
  logic [13:0] sy1_r, sy2_r, sy3_r;
  logic [5:0]  pend_r;
  dsq_state_t  state_r;
  logic [2:0]  cur_r, rr_r;
  logic        half_r, lastF_r, blkEnd_r, halfHit_r;
  logic        setup, apbWr, chHit;
  logic [2:0]  ach, rs;
  logic [5:0]  off;
  logic [5:0]  ready, stopCh;
  logic [3:0]  grant;
  logic        rdDone, wrDone, dbl, pairDone, auto_buffer_mode, elemLast, wordLast;
  logic [15:0] mc;

  assign setup  = psel && !penable;
  assign apbWr  = psel && penable && pwrite;
  assign ach    = paddr[8:6];
  assign off    = paddr[5:0];
  assign chHit  = paddr[11:9] == 3'h0 && ach < `DSQ_NUM_CH && off <= `DSQ_R_RL_FRM
                  && off[1:0] == 2'h0;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !chHit && !(paddr >= `DSQ_G_CTRL
                   && paddr <= `DSQ_G_FSTEP1 && paddr[1:0] == 2'h0);

  assign rs = ctrl_r[`DSQ_B_RLSEL] ? cur_r : 3'h0;
  assign mc = mode_r[cur_r];
  assign auto_buffer_mode = mc[`DSQ_B_ABU];
  assign dbl = sfc_r[cur_r][`DSQ_B_DBL];
  assign rdDone = state_r == DSQ_READ && memAck;
  assign wrDone = state_r == DSQ_WRITE && memAck;
  assign pairDone = !dbl || half_r;
  assign elemLast = auto_buffer_mode ? abuPos_r[cur_r] == elemCnt_r[cur_r] : elemCnt_r[cur_r] == 16'h0;
  assign wordLast = pairDone && elemLast;
  assign memReq = state_r != DSQ_IDLE;
  assign memWe  = state_r == DSQ_WRITE;

  ////////////////////////////////////////////////////////////////////////////
  // Sync events, two flops then edge detect
  always_ff @(posedge clk) begin
    if (reset) begin
      sy1_r <= 14'h0;
      sy2_r <= 14'h0;
      sy3_r <= 14'h0;
    end else begin
      sy1_r <= syncIn;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
    end
  end

  // event selection; set wins over the grant clear
  always_ff @(posedge clk) begin
    if (reset) begin
      pend_r <= 6'h0;
    end else begin
      for (int c = 0; c < 6; c++) begin
        logic [3:0] s;
        s = sfc_r[c][`DSQ_F_SYNC];
        if (s != `DSQ_SYNC_NONE && s != `DSQ_SYNC_RSVD && sy2_r[s - 4'h1] && !sy3_r[s - 4'h1])
          pend_r[c] <= 1'b1;
        else if (grant[3] && grant[2:0] == 3'(c))
          pend_r[c] <= 1'b0;
      end
    end
  end

  always_comb begin
    for (int c = 0; c < 6; c++) begin
      ready[c] = ctrl_r[c] && (sfc_r[c][`DSQ_F_SYNC] == `DSQ_SYNC_NONE || pend_r[c]);
    end
  end

  assign grant = (state_r != DSQ_IDLE) ? 4'h0 :
                 (|(ready & ctrl_r[`DSQ_F_PRIO])) ? pick(ready & ctrl_r[`DSQ_F_PRIO], rr_r)
                                                  : pick(ready, rr_r);

  assign stopCh = (wrDone && blkEnd_r && !auto_buffer_mode && !mc[`DSQ_B_AUTO]) ? 6'(1 << cur_r) : 6'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Global registers; a software write wins over the stop
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r   <= `DSQ_CTRL_RESET;
      eStep0_r <= 16'h0;
      eStep1_r <= 16'h0;
      fStep0_r <= 16'h0;
      fStep1_r <= 16'h0;
    end else begin
      // Only a control write may mask a stop; step writes must not lose it
      if (apbWr && paddr == `DSQ_G_CTRL) ctrl_r <= pwdata[15:0];
      else ctrl_r[`DSQ_F_EN] <= ctrl_r[`DSQ_F_EN] & ~stopCh;
      if (apbWr && paddr == `DSQ_G_ESTEP0) eStep0_r <= pwdata[15:0];
      else if (apbWr && paddr == `DSQ_G_ESTEP1) eStep1_r <= pwdata[15:0];
      else if (apbWr && paddr == `DSQ_G_FSTEP0) fStep0_r <= pwdata[15:0];
      else if (apbWr && paddr == `DSQ_G_FSTEP1) fStep1_r <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer engine
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r   <= DSQ_IDLE;
      cur_r     <= 3'h0;
      rr_r      <= 3'h5;
      half_r    <= 1'b0;
      lastF_r   <= 1'b0;
      blkEnd_r  <= 1'b0;
      halfHit_r <= 1'b0;
      memAddr   <= 16'h0;
      memWdata  <= 16'h0;
    end else begin
      case (state_r)
        DSQ_IDLE: begin
          if (grant[3]) begin
            cur_r   <= grant[2:0];
            rr_r    <= grant[2:0];
            memAddr <= srcA_r[grant[2:0]];
            state_r <= DSQ_READ;
          end
        end
        DSQ_READ: begin
          if (memAck) begin
            memWdata  <= memRdata;
            memAddr   <= dstA_r[cur_r];
            lastF_r   <= wordLast;
            blkEnd_r  <= wordLast && (auto_buffer_mode || sfc_r[cur_r][`DSQ_F_FRM] == 8'h0);
            halfHit_r <= pairDone && auto_buffer_mode && abuPos_r[cur_r] == {1'b0, elemCnt_r[cur_r][15:1]};
            state_r   <= DSQ_WRITE;
          end
        end
        DSQ_WRITE: begin
          if (memAck) begin
            if (dbl && !half_r) begin
              half_r  <= 1'b1;
              memAddr <= srcA_r[cur_r];
              state_r <= DSQ_READ;
            end else begin
              half_r  <= 1'b0;
              state_r <= DSQ_IDLE;
            end
          end
        end
        default: state_r <= DSQ_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel state; a software write lands after the engine update
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int c = 0; c < 6; c++) begin
        srcA_r[c] <= 16'h0;
        dstA_r[c] <= 16'h0;
        elemCnt_r[c] <= 16'h0;
        elemInit_r[c] <= 16'h0;
        abuPos_r[c] <= 16'h0;
        sfc_r[c] <= 16'h0;
        mode_r[c] <= 16'h0;
        rlSrc_r[c] <= 16'h0;
        rlDst_r[c] <= 16'h0;
        rlElem_r[c] <= 16'h0;
        rlFrm_r[c] <= 16'h0;
      end
    end else begin
      if (rdDone) begin
        srcA_r[cur_r] <= srcA_r[cur_r] + stepOf(mc[`DSQ_F_SIDX], wordLast,
                         eStep0_r, eStep1_r, fStep0_r, fStep1_r);
        if (pairDone && auto_buffer_mode) begin
          abuPos_r[cur_r] <= elemLast ? 16'h0 : abuPos_r[cur_r] + 16'h1;
        end else if (pairDone && elemLast) begin
          // zero frame count is the last frame
          if (sfc_r[cur_r][`DSQ_F_FRM] == 8'h0) begin
            if (mc[`DSQ_B_AUTO]) begin
              sfc_r[cur_r][`DSQ_F_FRM] <= rlFrm_r[rs][7:0];
              elemCnt_r[cur_r] <= rlElem_r[rs];
              elemInit_r[cur_r] <= rlElem_r[rs];
            end
          end else begin
            sfc_r[cur_r][`DSQ_F_FRM] <= sfc_r[cur_r][`DSQ_F_FRM] - 8'h1;
            elemCnt_r[cur_r] <= elemInit_r[cur_r];
          end
        end else if (pairDone) begin
          elemCnt_r[cur_r] <= elemCnt_r[cur_r] - 16'h1;
        end
      end
      if (wrDone) begin
        if (blkEnd_r && (auto_buffer_mode || mc[`DSQ_B_AUTO])) begin
          srcA_r[cur_r] <= rlSrc_r[rs];
          dstA_r[cur_r] <= rlDst_r[rs];
        end else begin
          dstA_r[cur_r] <= dstA_r[cur_r] + stepOf(mc[`DSQ_F_DIDX], lastF_r,
                           eStep0_r, eStep1_r, fStep0_r, fStep1_r);
        end
      end
      if (apbWr && chHit) begin
        if (off == `DSQ_R_SRC) srcA_r[ach] <= pwdata[15:0];
        else if (off == `DSQ_R_DST) dstA_r[ach] <= pwdata[15:0];
        else if (off == `DSQ_R_ELEM) begin
          elemCnt_r[ach] <= pwdata[15:0];
          elemInit_r[ach] <= pwdata[15:0];
          abuPos_r[ach] <= 16'h0;
        end
        else if (off == `DSQ_R_SYNCFRM) sfc_r[ach] <= pwdata[15:0];
        else if (off == `DSQ_R_MODE) mode_r[ach] <= pwdata[15:0];
        // reload values held until next reload
        else if (off == `DSQ_R_RL_SRC) rlSrc_r[ach] <= pwdata[15:0];
        else if (off == `DSQ_R_RL_DST) rlDst_r[ach] <= pwdata[15:0];
        else if (off == `DSQ_R_RL_ELEM) rlElem_r[ach] <= pwdata[15:0];
        else rlFrm_r[ach] <= pwdata[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in the setup cycle, so zero wait states
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (setup) begin
      prdata <= 32'h0;
      if (paddr == `DSQ_G_CTRL) prdata[15:0] <= ctrl_r;
      else if (paddr == `DSQ_G_ESTEP0) prdata[15:0] <= eStep0_r;
      else if (paddr == `DSQ_G_ESTEP1) prdata[15:0] <= eStep1_r;
      else if (paddr == `DSQ_G_FSTEP0) prdata[15:0] <= fStep0_r;
      else if (paddr == `DSQ_G_FSTEP1) prdata[15:0] <= fStep1_r;
      else if (chHit && off == `DSQ_R_SRC) prdata[15:0] <= srcA_r[ach];
      else if (chHit && off == `DSQ_R_DST) prdata[15:0] <= dstA_r[ach];
      else if (chHit && off == `DSQ_R_ELEM) prdata[15:0] <= elemCnt_r[ach];
      else if (chHit && off == `DSQ_R_SYNCFRM) prdata[15:0] <= sfc_r[ach];
      else if (chHit && off == `DSQ_R_MODE) prdata[15:0] <= mode_r[ach];
      else if (chHit && off == `DSQ_R_RL_SRC) prdata[15:0] <= rlSrc_r[ach];
      else if (chHit && off == `DSQ_R_RL_DST) prdata[15:0] <= rlDst_r[ach];
      else if (chHit && off == `DSQ_R_RL_ELEM) prdata[15:0] <= rlElem_r[ach];
      else if (chHit && off == `DSQ_R_RL_FRM) prdata[15:0] <= rlFrm_r[ach];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done interrupts, one-cycle pulse after the write completes
  always_ff @(posedge clk) begin
    if (reset) begin
      chanDoneIrq <= 6'h0;
    end else begin
      chanDoneIrq <= 6'h0;
      if (wrDone && pairDone && mc[`DSQ_B_INTGEN] && (blkEnd_r || (mc[`DSQ_B_INTMODE]
          && (auto_buffer_mode ? halfHit_r : lastF_r))))
        chanDoneIrq <= 6'(1 << cur_r);
    end
  end

  // shared line routing; reserved code keeps port sources
  always_comb begin
    irqLine6  = port2RxIrq;
    irqLine7  = port2TxIrq;
    irqLine10 = port1RxIrq;
    irqLine11 = port1TxIrq;
    if (ctrl_r[`DSQ_F_IRQSEL] == `DSQ_IRQ_HALF) begin
      irqLine10 = chanDoneIrq[2];
      irqLine11 = chanDoneIrq[3];
    end else if (ctrl_r[`DSQ_F_IRQSEL] == `DSQ_IRQ_ALL) begin
      irqLine6  = chanDoneIrq[0];
      irqLine7  = chanDoneIrq[1];
      irqLine10 = chanDoneIrq[2];
      irqLine11 = chanDoneIrq[3];
    end
  end

endmodule // dsq_channel_sequencer
`default_nettype wire

/* dsq_seq_assertions.sv */
// Concurrent checks on the channel sequencer ports
`default_nettype none
`include "dsq_map.svh"
module dsq_seq_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  // Memory side
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [15:0] memAddr,
  input wire logic [15:0] memWdata,
  input wire logic [15:0] memRdata,
  input wire logic        memAck,
  // Interrupts
  input wire logic        port2RxIrq,
  input wire logic        port1RxIrq,
  input wire logic [5:0]  chanDoneIrq,
  input wire logic        irqLine6,
  input wire logic        irqLine10
);
  logic [1:0] lineSel_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  //////////////////////////////
  // Shadow select, updated by the same APB write the block takes
  always_ff @(posedge clk) begin
    if (reset) begin
      lineSel_r <= `DSQ_IRQ_PORTS;
    end else if (psel && penable && pwrite && paddr == `DSQ_G_CTRL) begin
      lineSel_r <= pwdata[`DSQ_F_IRQSEL];
    end
  end
  //////////////////////////////
  read_first_a: assert property ($rose(memReq) |-> !memWe)
    else $error("word transfer opened with a write");
  read_then_write_a: assert property (memReq && !memWe && memAck |=> memReq && memWe)
    else $error("read not followed by its write");
  copy_data_a: assert property (memReq && !memWe && memAck |=> memWdata == $past(memRdata))
    else $error("written word differs from word read");
  hold_request_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
    else $error("request or address moved before answer");
  irq_after_write_a: assert property (|chanDoneIrq |-> $past(memReq && memWe && memAck))
    else $error("done interrupt without completed write");
  irq_single_pulse_a: assert property (|chanDoneIrq |=> chanDoneIrq == 6'h0)
    else $error("done interrupt longer than one cycle");
  line6_port_a: assert property (lineSel_r[1] == lineSel_r[0] |-> irqLine6 == port2RxIrq)
    else $error("line 6 not carrying port interrupt");
  line6_chan_a: assert property (lineSel_r == `DSQ_IRQ_ALL |-> irqLine6 == chanDoneIrq[0])
    else $error("line 6 not carrying channel 0");
  line10_chan_a: assert property (lineSel_r[1] != lineSel_r[0] |-> irqLine10 == chanDoneIrq[2])
    else $error("line 10 not carrying channel 2");
  line10_port_a: assert property (lineSel_r[1] == lineSel_r[0] |-> irqLine10 == port1RxIrq)
    else $error("line 10 not carrying port interrupt");
endmodule // dsq_seq_checker
bind dsq_channel_sequencer dsq_seq_checker chk (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
  .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .port2RxIrq(port2RxIrq),
  .port1RxIrq(port1RxIrq), .chanDoneIrq(chanDoneIrq), .irqLine6(irqLine6),
  .irqLine10(irqLine10)
);
`default_nettype wire

/* dsq_mem_partner.sv */
// Memory partner answering the sequencer's word accesses
`default_nettype none
module dsq_mem_partner (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Access from the sequencer
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [15:0] memAddr,
  input  wire logic [15:0] memWdata,
  output var  logic [15:0] memRdata,
  output var  logic        memAck,
  // Wait states per access
  input  wire logic [3:0]  waitCycles
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [256];
  logic [3:0]  cnt;
  // Preset pattern so every copied word is traceable
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hc300 | 16'(i);
    memRdata = 16'h0;
    memAck = 1'h0;
    cnt = 4'h0;
  end
  // Data toggles outside an answer, so a late sample never matches by luck
  always @(posedge clk) begin
    memAck <= 1'h0;
    memRdata <= ~memRdata;
    if (reset) begin
      cnt <= 4'h0;
    end else if (memReq && !memAck) begin
      if (cnt == waitCycles) begin
        memAck <= 1'h1;
        cnt <= 4'h0;
        if (memWe) begin
          mem[memAddr[7:0]] <= memWdata;
        end else begin
          memRdata <= mem[memAddr[7:0]];
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // dsq_mem_partner
`default_nettype wire

/* dsq_channel_sequencer_tb_top.sv */
// Self-checking bench of the channel sequencer
`default_nettype none
`include "dsq_map.svh"
module dsq_channel_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic        memReq, memWe, memAck;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] memAddr, memWdata, memRdata;
  logic [13:0] syncIn;
  logic [5:0]  chanDoneIrq;
  logic [3:0]  portIrq, irqLines, waitCycles;
  int          failures = 0, compares = 0, cycles = 0, writes = 0;
  int          irqCount [6] = '{0, 0, 0, 0, 0, 0};
  localparam logic [7:0] DST_LIST [4] = '{8'h80, 8'h83, 8'h8a, 8'h8d};
  dsq_channel_sequencer dut (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck), .syncIn(syncIn), .port2RxIrq(portIrq[0]),
    .port2TxIrq(portIrq[1]), .port1RxIrq(portIrq[2]), .port1TxIrq(portIrq[3]),
    .chanDoneIrq(chanDoneIrq), .irqLine6(irqLines[0]), .irqLine7(irqLines[1]),
    .irqLine10(irqLines[2]), .irqLine11(irqLines[3]));
  dsq_mem_partner part (
    .clk(clk), .reset(reset), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memRdata(memRdata), .memAck(memAck), .waitCycles(waitCycles));
  //////////////////////////////
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  // Counts words written and done pulses; the cycle ceiling cuts a hang short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (memReq === 1'h1 && memWe === 1'h1 && memAck === 1'h1) writes <= writes + 1;
    for (int i = 0; i < 6; i++) if (chanDoneIrq[i] === 1'h1) irqCount[i] <= irqCount[i] + 1;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  //////////////////////////////
  task print_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  function automatic logic [11:0] ra(input int ch, input logic [5:0] off);
    return 12'(ch * 64) + 12'(off);
  endfunction
  function automatic logic [15:0] md(input logic au, ig, im, input logic [2:0] s, d);
    return {au, ig, im, 2'h0, s, 5'h0, d};
  endfunction
  task setup(input int ch, input logic [15:0] src, dst, cnt, sf, mode);
    apb(1'h1, ra(ch, `DSQ_R_SRC), {16'h0, src});
    apb(1'h1, ra(ch, `DSQ_R_DST), {16'h0, dst});
    apb(1'h1, ra(ch, `DSQ_R_SYNCFRM), {16'h0, sf});
    apb(1'h1, ra(ch, `DSQ_R_ELEM), {16'h0, cnt});
    apb(1'h1, ra(ch, `DSQ_R_MODE), {16'h0, mode});
  endtask
  task waitWrites(input int n);
    while (writes < n) @(posedge clk);
  endtask
  //////////////////////////////
  task regsTest();
    apb(1'h0, `DSQ_G_CTRL, 32'h0);
    check(rd, {16'h0, `DSQ_CTRL_RESET});
    apb(1'h1, `DSQ_G_ESTEP1, 32'h1234);
    apb(1'h0, `DSQ_G_ESTEP1, 32'h0);
    check(rd, 32'h1234);
    apb(1'h1, 12'h1fc, 32'h5555);
    check({31'h0, err}, 32'h1);
    apb(1'h0, 12'h1fc, 32'h0);
    check(rd, 32'h0);
  endtask
  // Two frames of two elements; element step 3, frame step 7 on the destination
  task framesTest();
    int base, irqBase;
    apb(1'h1, `DSQ_G_ESTEP0, 32'h3);
    apb(1'h1, `DSQ_G_FSTEP0, 32'h7);
    for (int m = 0; m < 3; m++) begin
      base = writes;
      irqBase = irqCount[0];
      setup(0, 16'h10, 16'h80, 16'h1, 16'h1, md(1'h0, m > 0, m != 1, `DSQ_IDX_INC, `DSQ_IDX_SEL0));
      apb(1'h1, `DSQ_G_CTRL, 32'h81);
      waitWrites(base + 4);
      repeat (5) @(posedge clk);
      check(32'(writes - base), 32'h4);
      check(32'(irqCount[0] - irqBase), 32'(m));
      for (int k = 0; k < 4; k++) check(part.mem[DST_LIST[k]], 16'hc310 + 16'(k));
      apb(1'h0, `DSQ_G_CTRL, 32'h0);
      check(rd, 32'h80);
    end
  endtask
  // Doubleword element against a slow partner
  task dblTest();
    int base;
    base = writes;
    waitCycles <= 4'h3;
    setup(1, 16'h20, 16'h91, 16'h0, 16'h0800, md(1'h0, 1'h0, 1'h0, `DSQ_IDX_INC, `DSQ_IDX_DEC));
    apb(1'h1, `DSQ_G_CTRL, 32'h2);
    waitWrites(base + 2);
    repeat (12) @(posedge clk);
    check(32'(writes - base), 32'h2);
    check(part.mem[8'h91], 16'hc320);
    check(part.mem[8'h90], 16'hc321);
    waitCycles <= 4'h0;
  endtask
  // Second block comes from set zero or the channel's own set
  task reloadTest();
    int irqBase;
    for (int c = 0; c < 3; c += 2) begin
      apb(1'h1, ra(c, `DSQ_R_RL_SRC), 32'h50 - 32'(c * 8));
      apb(1'h1, ra(c, `DSQ_R_RL_DST), 32'hc0 - 32'(c * 16));
      apb(1'h1, ra(c, `DSQ_R_RL_ELEM), 32'h1);
    end
    for (int s = 0; s < 2; s++) begin
      irqBase = irqCount[2];
      setup(2, 16'h30, 16'hb0, 16'h0, 16'h0, md(1'h1, 1'h1, 1'h0, `DSQ_IDX_INC, `DSQ_IDX_INC));
      apb(1'h1, `DSQ_G_CTRL, 32'h44 | 32'(s << 14));
      while (irqCount[2] < irqBase + 2) @(posedge clk);
      apb(1'h1, `DSQ_G_CTRL, 32'h0);
      repeat (10) @(posedge clk);
      check(part.mem[8'hb0], 16'hc330);
      check(part.mem[8'hc1], 16'hc351);
      check(part.mem[8'ha1], s ? 16'hc341 : 16'hc3a1);
    end
  endtask
  // Only the chosen event may start the channel
  task syncTest();
    int base;
    base = writes;
    setup(3, 16'h60, 16'hd0, 16'h0, 16'he000, md(1'h0, 1'h0, 1'h0, `DSQ_IDX_INC, `DSQ_IDX_INC));
    apb(1'h1, `DSQ_G_CTRL, 32'h8);
    syncIn <= 14'h1fff;
    repeat (10) @(posedge clk);
    syncIn <= 14'h0;
    repeat (10) @(posedge clk);
    check(32'(writes - base), 32'h0);
    syncIn <= 14'h2000;
    waitWrites(base + 1);
    syncIn <= 14'h0;
    check(part.mem[8'hd0], 16'hc360);
  endtask
  // Four-word auto-buffer: full only, then half and full
  task abuTest();
    int base, irqBase;
    for (int m = 0; m < 2; m++) begin
      base = writes;
      irqBase = irqCount[4];
      setup(4, 16'h70, 16'he0, 16'h3, 16'h0,
            md(1'h0, 1'h1, 1'(m), `DSQ_IDX_INC, `DSQ_IDX_INC) | 16'(1 << `DSQ_B_ABU));
      apb(1'h1, `DSQ_G_CTRL, 32'h10);
      waitWrites(base + 4);
      repeat (2) @(posedge clk);
      check(32'(irqCount[4] - irqBase), 32'(m + 1));
      check(part.mem[8'he3], 16'hc373);
      apb(1'h1, `DSQ_G_CTRL, 32'h0);
      repeat (10) @(posedge clk);
    end
  endtask
  task muxTest();
    for (int s = 0; s < 4; s++) begin
      apb(1'h1, `DSQ_G_CTRL, 32'(s << 6));
      portIrq <= 4'h6;
      @(posedge clk);
      #1;
      check(irqLines, s == 2 ? 4'h0 : s == 1 ? 4'h2 : 4'h6);
    end
    portIrq <= 4'h0;
  endtask
  //////////////////////////////
  initial begin
    reset = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    syncIn = 14'h0;
    portIrq = 4'h0;
    waitCycles = 4'h0;
    repeat (8) @(posedge clk);
    reset <= 1'h0;
    regsTest();
    framesTest();
    dblTest();
    reloadTest();
    syncTest();
    abuTest();
    muxTest();
    print_verdict();
  end
endmodule // dsq_channel_sequencer_tb_top
`default_nettype wire
